// *** hw/iie_cfg.svh ***
// timing, offsets, field positions and reset values for the interrupt enable gating block
// assumes inclusion from the package, the top module and the bench top
`ifndef IIE_CFG_SVH
`define IIE_CFG_SVH
`define IIE_ADDR_W 2
`define IIE_OFS_CTRL 2'h0
`define IIE_OFS_STATUS 2'h1
`define IIE_OFS_MASK 2'h2
`define IIE_OFS_FLAGS 2'h3
`define IIE_BIT_EVT_EN 9
`define IIE_BIT_ERR_EN 8
`define IIE_BIT_BUF_EN 10
`define IIE_PERIPHERAL_CLOCK_MHZ_MSB 5
`define IIE_CTRL_RST 32'h00000000
`define IIE_CTRL_WMASK 32'h0000073F
`define IIE_PERIPHERAL_CLOCK_MHZ_MIN 6'h04
`define IIE_PERIPHERAL_CLOCK_MHZ_MAX 6'h3C
`define IIE_ST_EVT 0
`define IIE_ST_ERR 1
`define IIE_ST_PERIPHERAL_CLOCK_MHZ 2
`define IIE_ST_W 3
`define IIE_UNMAPPED 32'h00000000
`endif

// *** hw/iie_pkg.sv ***
// types shared by the interrupt enable gating block
// assumes iie_cfg.svh sits beside it
`include "iie_cfg.svh"
package iie_pkg;
    // bus slave answer states, gray along idle->answer
    typedef enum logic [0:0] {
        IIE_IDLE = 1'b0,
        IIE_RESP = 1'b1
    } iie_bus_state_t;
    typedef logic [`IIE_ST_W-1:0] iie_status_t;
endpackage

// *** hw/iie_gate.sv ***
// combinational gating of controller flags into event and error requests
// assumes flags are already synchronous to i_clock
module iie_gate
    import iie_pkg::*;
(
    input wire logic i_event_irq_enable, // event interrupt enable
    input wire logic i_error_irq_enable, // error interrupt enable
    input wire logic i_buffer_irq_enable, // buffer interrupt enable
    input wire logic i_master, // master role
    input wire logic i_ten_bit_header_sent, // ten-bit header sent
    input wire logic i_stop_detected, // stop seen
    input wire logic i_byte_transfer_finished, // byte done
    input wire logic i_tx_empty, // transmit empty
    input wire logic i_rx_not_empty, // receive not empty
    input wire logic [6:0] i_err_flags, // error flag group
    output logic o_event_req, // gated event request
    output logic o_error_req // gated error request
);
    logic buf_evt; // buffer events
    logic core_evt; // non-buffer events
    always_comb begin
        buf_evt = i_tx_empty | i_rx_not_empty;
        // header in master role, stop in slave role
        core_evt = (i_master & i_ten_bit_header_sent) | (~i_master & i_stop_detected);
        // byte done counts even with no buffer event pending
        core_evt = core_evt | i_byte_transfer_finished;
        // buffer events need both enables
        o_event_req = i_event_irq_enable & (core_evt | (i_buffer_irq_enable & buf_evt));
        o_error_req = i_error_irq_enable & (|i_err_flags);
    end
endmodule // iie_gate

// *** hw/iie_top.sv ***
// interrupt enable gating and clock frequency control with an avalon-mm slave
// assumes flags come from logic on i_clock; bus master holds requests until waitrequest low
//
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`include "iie_cfg.svh"
// Notes on behaviour
// - event irq on header (master) or stop (slave)
// - byte done raises event irq alone
// - buffer events need buffer enable too
// - error enable bit 8, resets zero
// - error irq on any error flag
module iie_top
    import iie_pkg::*;
(
    input wire logic i_clock, // 100 MHz clock
    input wire logic i_rst, // sync reset, active high
    input wire logic [`IIE_ADDR_W-1:0] i_address, // word address
    input wire logic i_read, // read strobe
    input wire logic i_write, // write strobe
    input wire logic [31:0] i_writedata, // write data
    input wire logic [3:0] i_byteenable, // byte enables
    output logic [31:0] o_readdata, // read data
    output logic o_waitrequest, // stall
    input wire logic i_master, // controller in master role
    input wire logic i_ten_bit_header_sent, // flag
    input wire logic i_stop_detected, // flag
    input wire logic i_byte_transfer_finished, // flag
    input wire logic i_tx_empty, // flag
    input wire logic i_rx_not_empty, // flag
    input wire logic i_bus_error, // flag
    input wire logic i_arbitration_lost, // flag
    input wire logic i_ack_failure, // flag
    input wire logic i_overrun_underrun, // flag
    input wire logic i_packet_check_error, // flag
    input wire logic i_timeout, // flag
    input wire logic i_smbus_alert, // flag
    output logic o_event_irq, // event interrupt level
    output logic o_error_irq, // error interrupt level
    output logic [5:0] o_peripheral_clock_mhz, // to timing generator
    output logic o_irq // masked status interrupt
);
    logic [31:0] ctrl; // control register
    iie_status_t status; // sticky events
    iie_status_t mask; // status mask
    iie_bus_state_t state; // slave state
    logic event_req; // gated event request
    logic error_req; // gated error request
    logic event_req_d; // for rise detection
    logic error_req_d; // for rise detection
    logic peripheral_clock_mhz_bad; // frequency outside range
    logic wr_hit; // write accepted this cycle
    iie_status_t set_bits; // new events
    logic [31:0] wmask; // byte lane mask

    // byte enables widened to a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    iie_gate u_gate (
        .i_event_irq_enable(ctrl[`IIE_BIT_EVT_EN]),
        .i_error_irq_enable(ctrl[`IIE_BIT_ERR_EN]),
        .i_buffer_irq_enable(ctrl[`IIE_BIT_BUF_EN]),
        .i_master(i_master),
        .i_ten_bit_header_sent(i_ten_bit_header_sent),
        .i_stop_detected(i_stop_detected),
        .i_byte_transfer_finished(i_byte_transfer_finished),
        .i_tx_empty(i_tx_empty),
        .i_rx_not_empty(i_rx_not_empty),
        .i_err_flags({i_bus_error, i_arbitration_lost, i_ack_failure, i_overrun_underrun,
                      i_packet_check_error, i_timeout, i_smbus_alert}),
        .o_event_req(event_req),
        .o_error_req(error_req)
    );

    // one wait cycle then answer; keeps read data registered
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state <= IIE_IDLE;
        end else begin
            unique case (state)
                IIE_IDLE: begin
                    if (i_read | i_write) begin
                        state <= IIE_RESP;
                    end
                end
                IIE_RESP: begin
                    state <= IIE_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        o_waitrequest = (i_read | i_write) & (state == IIE_IDLE);
        wr_hit = i_write & (state == IIE_RESP);
        wmask = lane_mask(i_byteenable);
    end

    // control register: enables reset to zero, reserved bits stay zero
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ctrl <= `IIE_CTRL_RST;
        end else if (wr_hit && i_address == `IIE_OFS_CTRL) begin
            ctrl <= (ctrl & ~(wmask & `IIE_CTRL_WMASK)) | (i_writedata & wmask & `IIE_CTRL_WMASK);
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            mask <= '0;
        end else if (wr_hit && i_address == `IIE_OFS_MASK && i_byteenable[0]) begin
            mask <= i_writedata[`IIE_ST_W-1:0];
        end
    end

    // software owns the value; only flag it if out of range
    always_comb begin
        o_peripheral_clock_mhz = ctrl[`IIE_PERIPHERAL_CLOCK_MHZ_MSB:0];
        peripheral_clock_mhz_bad = (ctrl[`IIE_PERIPHERAL_CLOCK_MHZ_MSB:0] < `IIE_PERIPHERAL_CLOCK_MHZ_MIN) | (ctrl[`IIE_PERIPHERAL_CLOCK_MHZ_MSB:0] > `IIE_PERIPHERAL_CLOCK_MHZ_MAX);
        set_bits = '0;
        set_bits[`IIE_ST_EVT] = event_req & ~event_req_d;
        set_bits[`IIE_ST_ERR] = error_req & ~error_req_d;
        set_bits[`IIE_ST_PERIPHERAL_CLOCK_MHZ] = peripheral_clock_mhz_bad;
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            event_req_d <= 1'b0;
            error_req_d <= 1'b0;
        end else begin
            event_req_d <= event_req;
            error_req_d <= error_req;
        end
    end

    // sticky status, write one clears, set wins over clear
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            status <= '0;
        end else if (wr_hit && i_address == `IIE_OFS_STATUS && i_byteenable[0]) begin
            status <= (status & ~i_writedata[`IIE_ST_W-1:0]) | set_bits;
        end else begin
            status <= status | set_bits;
        end
    end

    // request levels follow the gated flags one edge later; held while any qualifying flag stays set
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_event_irq <= 1'b0;
            o_error_irq <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            o_event_irq <= event_req;
            o_error_irq <= error_req;
            o_irq <= |(status & mask);
        end
    end

    // read data registered on the answer cycle; all four word addresses are mapped
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_readdata <= '0;
        end else if (i_read && state == IIE_IDLE) begin
            unique case (i_address)
                `IIE_OFS_CTRL: o_readdata <= ctrl;
                `IIE_OFS_STATUS: o_readdata <= {29'h0, status};
                `IIE_OFS_MASK: o_readdata <= {29'h0, mask};
                `IIE_OFS_FLAGS: o_readdata <= {20'h0, i_master, i_smbus_alert, i_timeout,
                                               i_packet_check_error, i_overrun_underrun, i_ack_failure,
                                               i_arbitration_lost, i_bus_error, i_rx_not_empty, i_tx_empty,
                                               i_byte_transfer_finished, i_stop_detected};
            endcase
        end
    end

    // gating checks: the request outputs are registered, so each consequent looks one edge later
    a_evt_gate: assert property (@(posedge i_clock) disable iff (i_rst)
        (ctrl[`IIE_BIT_EVT_EN] && i_master && i_ten_bit_header_sent) |=> o_event_irq)
        else $error("event irq missed header");
    a_stop_slave: assert property (@(posedge i_clock) disable iff (i_rst)
        (ctrl[`IIE_BIT_EVT_EN] && !i_master && i_stop_detected) |=> o_event_irq)
        else $error("event irq missed stop");
    a_btf_evt: assert property (@(posedge i_clock) disable iff (i_rst)
        (ctrl[`IIE_BIT_EVT_EN] && i_byte_transfer_finished) |=> o_event_irq)
        else $error("event irq missed byte done");
    a_buf_gate: assert property (@(posedge i_clock) disable iff (i_rst)
        (!ctrl[`IIE_BIT_BUF_EN] && !i_byte_transfer_finished && !i_stop_detected && !i_ten_bit_header_sent)
        |=> !o_event_irq)
        else $error("buffer event leaked");
    a_err_en_rst: assert property (@(posedge i_clock)
        i_rst |=> !ctrl[`IIE_BIT_ERR_EN] && !o_error_irq)
        else $error("error enable not reset");
    a_err_gate: assert property (@(posedge i_clock) disable iff (i_rst)
        (ctrl[`IIE_BIT_ERR_EN] && i_bus_error) |=> o_error_irq)
        else $error("error irq missed bus error");
    a_peripheral_clock_mhz_out: assert property (@(posedge i_clock) disable iff (i_rst)
        (wr_hit && i_address == `IIE_OFS_CTRL && i_byteenable[0]) |=> o_peripheral_clock_mhz == $past(i_writedata[5:0]))
        else $error("frequency not loaded");
    a_err_off: assert property (@(posedge i_clock) disable iff (i_rst)
        !ctrl[`IIE_BIT_ERR_EN] |=> !o_error_irq)
        else $error("error irq without enable");
    // buffer events pass once both enables are up
    a_buf_pass: assert property (@(posedge i_clock) disable iff (i_rst)
        (ctrl[`IIE_BIT_EVT_EN] && ctrl[`IIE_BIT_BUF_EN] && (i_tx_empty || i_rx_not_empty)) |=> o_event_irq)
        else $error("buffer event dropped");
    // every error source counts, not only the bus error
    a_err_any: assert property (@(posedge i_clock) disable iff (i_rst)
        (ctrl[`IIE_BIT_ERR_EN] && (i_arbitration_lost || i_ack_failure || i_overrun_underrun
            || i_packet_check_error || i_timeout || i_smbus_alert)) |=> o_error_irq)
        else $error("error irq missed a source");
    // byte-done flag seen over two edges with event interrupts enabled
    sequence s_btf_held;
        (ctrl[`IIE_BIT_EVT_EN] && i_byte_transfer_finished)
            ##1 (ctrl[`IIE_BIT_EVT_EN] && i_byte_transfer_finished);
    endsequence
    // the request stays up for as long as its flag does, no one-cycle pulse
    a_req_held: assert property (@(posedge i_clock) disable iff (i_rst)
        s_btf_held |=> (o_event_irq && $past(o_event_irq)))
        else $error("event irq dropped while flag held");
    // a rising gated request, as the status logic sees it
    sequence s_evt_rise;
        event_req && !event_req_d;
    endsequence
    // set wins over a clear in the same cycle, so the bit is always caught
    a_evt_sticky: assert property (@(posedge i_clock) disable iff (i_rst)
        s_evt_rise |=> status[`IIE_ST_EVT])
        else $error("event status not latched");
endmodule // iie_top

// *** bench/iie_flag_model.sv ***
// flag source standing in for the controller's bus-side status logic
// assumes the bench loads a new flag set right after a rising edge
module iie_flag_model (
    input wire logic i_clock, // bench clock
    input wire logic i_rst, // sync reset, active high
    input wire logic i_load, // take a new flag set
    input wire logic [12:0] i_flags, // requested flag set
    output logic [12:0] o_flags // flags as the block sees them
);
    timeunit 1ns;
    timeprecision 1ps;
    // flags stay up until withdrawn, as real status bits do; one cycle of lag
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_flags <= 13'h0000;
        end else if (i_load) begin
            o_flags <= i_flags;
        end
    end
endmodule // iie_flag_model

// *** bench/tb_top.sv ***
// bench top: drives the gating block over avalon-mm and through the flag model
// assumes the hw/ files compile first; flags: [0] header [1] stop [2] byte done [3] tx [4] rx [11:5] errors [12] master
`include "iie_cfg.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock = 1'b0; // bench clock
    logic i_rst = 1'b1; // held for 12 cycles
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    logic [1:0] i_address = 2'h0;
    logic [31:0] i_writedata = 32'h00000000;
    logic [31:0] o_readdata, rd, ctrl;
    logic o_waitrequest, o_event_irq, o_error_irq, o_irq;
    logic [5:0] o_peripheral_clock_mhz;
    logic load = 1'b0; // model load strobe
    logic [12:0] cmd = 13'h0000, f;
    logic [12:0] fl; // random flag set of the current step
    logic [3:0] be = 4'hF; // byte enables, narrowed for the lane case only
    logic [12:0] tv [6] = '{13'h0001, 13'h1001, 13'h0002, 13'h1002, 13'h0004, 13'h0008};
    int failures = 0, n_tests = 0, seed = 32'hF204A83F;
    iie_flag_model model_u (.i_clock(i_clock), .i_rst(i_rst), .i_load(load), .i_flags(cmd), .o_flags(f));
    iie_top dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_address(i_address), .i_read(i_read), .i_write(i_write),
        .i_writedata(i_writedata), .i_byteenable(be), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
        .i_master(f[12]), .i_ten_bit_header_sent(f[0]), .i_stop_detected(f[1]), .i_byte_transfer_finished(f[2]),
        .i_tx_empty(f[3]), .i_rx_not_empty(f[4]), .i_bus_error(f[5]), .i_arbitration_lost(f[6]),
        .i_ack_failure(f[7]), .i_overrun_underrun(f[8]), .i_packet_check_error(f[9]), .i_timeout(f[10]),
        .i_smbus_alert(f[11]), .o_event_irq(o_event_irq), .o_error_irq(o_error_irq),
        .o_peripheral_clock_mhz(o_peripheral_clock_mhz), .o_irq(o_irq));
    // free-running 100 MHz clock
    initial begin
        forever #5 i_clock = ~i_clock;
    end
    // verdict and end of run, the one exit
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // one comparison, counted
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one interrupt level comparison; unknowns still fail through the word compare
    task automatic chk_bit(input logic got, input logic exp);
        chk(32'(got), 32'(exp));
    endtask
    // one avalon access; request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic [1:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge i_clock);
        i_address <= a;
        i_write <= wr;
        i_read <= !wr;
        i_writedata <= d;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_waitrequest !== 1'b0 && n < 20);
        // read data taken at the accepting edge, release by nba at that same edge
        q = o_readdata;
        i_read <= 1'b0;
        i_write <= 1'b0;
        if (n >= 20) begin
            failures++;
            complete_run();
        end
    endtask
    // load flags, then wait out model lag plus the registered irq stage
    task automatic apply(input logic [12:0] fv);
        @(posedge i_clock);
        cmd <= fv;
        load <= 1'b1;
        @(posedge i_clock);
        load <= 1'b0;
        repeat (2) @(posedge i_clock);
        @(negedge i_clock);
    endtask
    // expected event request from enables and flags
    function automatic logic exp_evt(input logic [31:0] c, input logic [12:0] v);
        return c[9] & ((v[12] & v[0]) | (!v[12] & v[1]) | v[2] | (c[10] & (v[3] | v[4])));
    endfunction
    // expected error request: any of the seven error flags with the error enable
    function automatic logic exp_err(input logic [31:0] c, input logic [12:0] v);
        return c[8] & (|v[11:5]);
    endfunction
    // a hung design must still reach the verdict
    initial begin
        repeat (20000) @(posedge i_clock);
        failures++;
        complete_run();
    end
    initial begin
        repeat (12) @(posedge i_clock);
        i_rst <= 1'b0;
        // reset values; a zero frequency is outside the allowed range and gets flagged
        bus(`IIE_OFS_CTRL, 1'b0, 32'h00000000, rd);
        chk(rd, `IIE_CTRL_RST);
        chk(32'({o_event_irq, o_error_irq, o_irq}), 32'h00000000);
        bus(`IIE_OFS_STATUS, 1'b0, 32'h00000000, rd);
        chk(rd, 32'h00000004);
        // each error flag alone, event side off
        bus(`IIE_OFS_CTRL, 1'b1, 32'h0000010A, rd);
        for (int k = 0; k < 7; k++) begin
            apply(13'h0001 << (k + 5));
            chk_bit(o_error_irq, 1'b1);
            chk_bit(o_event_irq, 1'b0);
        end
        bus(`IIE_OFS_STATUS, 1'b0, 32'h00000000, rd);
        chk(rd & 32'h00000002, 32'h00000002);
        // role qualification, byte done alone, buffer events held back
        ctrl = 32'h0000023C;
        bus(`IIE_OFS_CTRL, 1'b1, ctrl, rd);
        for (int k = 0; k < 6; k++) begin
            apply(tv[k]);
            chk_bit(o_event_irq, exp_evt(ctrl, tv[k]));
        end
        // random enables, in-range frequency and flag mixes
        for (int k = 0; k < 30; k++) begin
            ctrl = (32'($random(seed)) & 32'h00000700) | 32'(((32'($random(seed)) & 32'h7FFFFFFF) % 57) + 4);
            bus(`IIE_OFS_CTRL, 1'b1, ctrl, rd);
            bus(`IIE_OFS_CTRL, 1'b0, 32'h00000000, rd);
            chk(rd, ctrl & `IIE_CTRL_WMASK);
            chk(32'(o_peripheral_clock_mhz), ctrl & 32'h0000003F);
            fl = 13'($random(seed));
            apply(fl);
            chk_bit(o_event_irq, exp_evt(ctrl, fl));
            chk_bit(o_error_irq, exp_err(ctrl, fl));
        end
        // status, mask and the combined interrupt line
        apply(13'h0000);
        bus(`IIE_OFS_STATUS, 1'b1, 32'h00000007, rd);
        bus(`IIE_OFS_MASK, 1'b1, 32'h00000001, rd);
        bus(`IIE_OFS_CTRL, 1'b1, 32'h00000204, rd);
        apply(13'h0004);
        chk_bit(o_irq, 1'b1);
        bus(`IIE_OFS_STATUS, 1'b0, 32'h00000000, rd);
        chk(rd & 32'h00000001, 32'h00000001);
        apply(13'h0000);
        bus(`IIE_OFS_STATUS, 1'b1, 32'h00000001, rd);
        bus(`IIE_OFS_STATUS, 1'b0, 32'h00000000, rd);
        chk(rd & 32'h00000001, 32'h00000000);
        chk_bit(o_irq, 1'b0);
        bus(`IIE_OFS_MASK, 1'b1, 32'h00000000, rd);
        apply(13'h0004);
        chk_bit(o_irq, 1'b0);
        chk_bit(o_event_irq, 1'b1);
        // low lane only: enables keep their value, the frequency field follows
        be <= 4'h1;
        bus(`IIE_OFS_CTRL, 1'b1, 32'h0000053C, rd);
        be <= 4'hF;
        bus(`IIE_OFS_CTRL, 1'b0, 32'h00000000, rd);
        chk(rd, 32'h0000023C);
        complete_run();
    end
endmodule // tb_top
